/* rtl/slsmon_pkg.sv */
// Package: constants and types for the safe limited speed monitor
package slsmon_pkg;
  // Levels and data widths
  localparam int SLSMON_LEVELS = 4;
  localparam int SLSMON_VEL_W = 16;
  localparam int SLSMON_RAMP_W = 24;
  // Response bound, in microseconds, and the derived cycle budget
  localparam int SLSMON_CLK_MHZ = 200;
  localparam int SLSMON_RESP_US = 10000;
  localparam int SLSMON_RESP_CYC = SLSMON_RESP_US * SLSMON_CLK_MHZ;
  // Register offsets (byte addresses)
  localparam logic [7:0] SLSMON_A_CTRL = 8'h00;
  localparam logic [7:0] SLSMON_A_LIM0 = 8'h04;
  localparam logic [7:0] SLSMON_A_RAMP = 8'h14;
  localparam logic [7:0] SLSMON_A_REACT = 8'h18;
  localparam logic [7:0] SLSMON_A_STAT = 8'h1c;
  localparam logic [7:0] SLSMON_A_IRQ_ST = 8'h20;
  localparam logic [7:0] SLSMON_A_IRQ_CLR = 8'h24;
  localparam logic [7:0] SLSMON_A_IRQ_EN = 8'h28;
  // Field positions
  localparam int SLSMON_SW_ACTIVE = 4;
  localparam int SLSMON_SW_SEL_LO = 9;
  localparam int SLSMON_SW_SEL_HI = 10;
  // Reset values
  localparam logic [SLSMON_VEL_W-1:0] SLSMON_LIM_RST = 16'hffff;
  localparam logic [SLSMON_RAMP_W-1:0] SLSMON_RAMP_RST = 24'h000010;
  localparam logic [7:0] SLSMON_REACT_RST = 8'h00;
  localparam logic [1:0] SLSMON_LVL_RST = 2'h0;
  // Fault reaction codes
  typedef enum logic [1:0] {
    SLSMON_TORQUE_REMOVAL = 2'h0,
    SLSMON_STOP_CAT_ONE = 2'h1,
    SLSMON_STOP_CAT_TWO = 2'h2,
    SLSMON_OP_STOP_HOLD = 2'h3
  } slsmon_react_t;
  // Supervision state machine
  typedef enum logic [2:0] {
    SLSMON_IDLE = 3'b001,
    SLSMON_RAMP = 3'b010,
    SLSMON_MON = 3'b100
  } slsmon_state_t;
endpackage

/* rtl/slsmon_lvl_sync.sv */
// Two-stage synchroniser for one pin bit
`timescale 1ns/1ps
`default_nettype none
module slsmon_lvl_sync (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Pin and synchronised level
  input wire logic i_pin,
  output logic o_lvl
);
  logic meta_q;
  // First stage feeds only the second
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      meta_q <= 1'b0;
      o_lvl <= 1'b0;
    end else begin
      meta_q <= i_pin;
      o_lvl <= meta_q;
    end
  end
endmodule // slsmon_lvl_sync
`default_nettype wire

/* rtl/slsmon_top.sv */
// Safe limited speed monitor: request merge, ramp delay, speed check
//
// Contract
// - Either fieldbus or input request activates
// - Four levels, each with own limit
// - Per-level fault reaction, applied for monitored level
// - Concurrent requests: lowest limit wins
// - Respond to requests within ten milliseconds; activation waits the full ramp count, not capped at SLSMON_RESP_CYC
// - Lowering waits configured ramp-down time
// - Raising limit applies immediately
// - Active: over-speed triggers configured reaction
// - Deactivate only when all sources inactive
// - Reactions: torque removal, stop one, two, hold
// - Status word reports level in two bits
// - Safe output driven when any level active
`timescale 1ns/1ps
`default_nettype none
module slsmon_top
  import slsmon_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // Request sources
  input wire logic [3:0] i_bus_req,
  input wire logic [3:0] i_pin_req,
  input wire logic [3:0] i_int_req,
  // Measured safe velocity, magnitude
  input wire logic [15:0] i_safe_vel,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Status and reactions
  output logic [15:0] o_status_word,
  output logic o_safe_out,
  output logic o_torque_removal,
  output logic o_stop_one,
  output logic o_stop_two,
  output logic o_op_stop_hold,
  output logic o_irq
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] lim_q [SLSMON_LEVELS];
  logic [23:0] ramp_q;
  logic [7:0] react_q;
  logic safe_out_en_q;
  logic [2:0] irq_st_q;
  logic [2:0] irq_en_q;
  logic [3:0] pin_sync;
  slsmon_state_t state_q;
  logic [1:0] lvl_q;
  logic [1:0] tgt_q;
  logic [23:0] cnt_q;
  logic fault_q;
  logic [1:0] fault_react_q;
  logic [1:0] enf_lvl_q;
  logic hold_q;

  // Digital inputs come from pins, so synchronise each bit
  genvar gi;
  generate
    for (gi = 0; gi < SLSMON_LEVELS; gi++) begin : g_sync
      slsmon_lvl_sync u_sync (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_pin(i_pin_req[gi]),
        .o_lvl(pin_sync[gi])
      );
    end
  endgenerate

  // ****************************************************************
  // Request merge and level choice
  // ****************************************************************
  logic [3:0] req;
  logic any_req;
  logic [1:0] pick;
  // Any source raises a level request
  assign req = i_bus_req | pin_sync | i_int_req;
  assign any_req = |req;

  // Lowest configured limit among requested levels
  always_comb begin
    pick = 2'h0;
    for (int k = SLSMON_LEVELS - 1; k >= 0; k--) begin
      if (req[k] && (!req[pick] || lim_q[k] <= lim_q[pick])) begin
        pick = 2'(k);
      end
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      for (int k = 0; k < SLSMON_LEVELS; k++) begin
        lim_q[k] <= SLSMON_LIM_RST;
      end
      ramp_q <= SLSMON_RAMP_RST;
      react_q <= SLSMON_REACT_RST;
      safe_out_en_q <= 1'b0;
      irq_en_q <= 3'h0;
    end else if (i_wr) begin
      case (i_addr)
        SLSMON_A_CTRL: safe_out_en_q <= i_wdata[0];
        SLSMON_A_RAMP: ramp_q <= i_wdata[23:0];
        SLSMON_A_REACT: react_q <= i_wdata[7:0];
        SLSMON_A_IRQ_EN: irq_en_q <= i_wdata[2:0];
        default: begin
          for (int k = 0; k < SLSMON_LEVELS; k++) begin
            if (i_addr == SLSMON_A_LIM0 + 8'(4 * k)) begin
              lim_q[k] <= i_wdata[15:0];
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Supervision state machine
  // ****************************************************************
  // A pick at or above the enforced limit needs no ramp; with nothing
  // enforced yet (start from idle) every pick has to ramp first
  logic up_ok;
  assign up_ok = hold_q && lim_q[pick] >= lim_q[enf_lvl_q];

  // Selected level follows at once; enforced level only when allowed
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_q <= SLSMON_IDLE;
      lvl_q <= SLSMON_LVL_RST;
      tgt_q <= SLSMON_LVL_RST;
      enf_lvl_q <= SLSMON_LVL_RST;
      hold_q <= 1'b0;
      cnt_q <= 24'h0;
    end else begin
      case (state_q)
        SLSMON_IDLE: begin
          if (any_req) begin
            tgt_q <= pick;
            lvl_q <= pick;
            cnt_q <= ramp_q;
            state_q <= SLSMON_RAMP;
          end
        end
        SLSMON_RAMP: begin
          if (!any_req) begin
            hold_q <= 1'b0;
            state_q <= SLSMON_IDLE;
          end else if (pick != tgt_q && up_ok) begin
            tgt_q <= pick;
            lvl_q <= pick;
            enf_lvl_q <= pick;
            state_q <= SLSMON_MON;
          end else if (pick != tgt_q) begin
            tgt_q <= pick;
            lvl_q <= pick;
            cnt_q <= ramp_q;
          end else if (cnt_q <= 24'h1) begin
            enf_lvl_q <= tgt_q;
            hold_q <= 1'b1;
            state_q <= SLSMON_MON;
          end else begin
            cnt_q <= cnt_q - 24'h1;
          end
        end
        SLSMON_MON: begin
          if (!any_req) begin
            hold_q <= 1'b0;
            state_q <= SLSMON_IDLE;
          end else if (pick != lvl_q && up_ok) begin
            tgt_q <= pick;
            lvl_q <= pick;
            enf_lvl_q <= pick;
          end else if (pick != lvl_q) begin
            tgt_q <= pick;
            lvl_q <= pick;
            cnt_q <= ramp_q;
            state_q <= SLSMON_RAMP;
          end
        end
        default: begin
          hold_q <= 1'b0;
          state_q <= SLSMON_IDLE;
        end
      endcase
    end
  end

  // Old limit stays enforced through a lowering ramp
  logic checking;
  assign checking = hold_q;

  // ****************************************************************
  // Speed check and fault reaction
  // ****************************************************************
  // Fault latches until reset; a trip must not clear by itself
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      fault_q <= 1'b0;
      fault_react_q <= 2'h0;
    end else if (!fault_q && checking &&
                 i_safe_vel > lim_q[enf_lvl_q]) begin
      fault_q <= 1'b1;
      fault_react_q <= react_q[2*enf_lvl_q +: 2];
    end
  end

  // Decode the latched reaction onto one output each
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_torque_removal <= 1'b0;
      o_stop_one <= 1'b0;
      o_stop_two <= 1'b0;
      o_op_stop_hold <= 1'b0;
    end else begin
      o_torque_removal <= fault_q &&
        fault_react_q == SLSMON_TORQUE_REMOVAL;
      o_stop_one <= fault_q && fault_react_q == SLSMON_STOP_CAT_ONE;
      o_stop_two <= fault_q && fault_react_q == SLSMON_STOP_CAT_TWO;
      o_op_stop_hold <= fault_q && fault_react_q == SLSMON_OP_STOP_HOLD;
    end
  end

  // ****************************************************************
  // Status word, safe output
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_status_word <= 16'h0;
      o_safe_out <= 1'b0;
    end else begin
      o_status_word <= 16'h0;
      o_status_word[SLSMON_SW_ACTIVE] <= hold_q;
      o_status_word[SLSMON_SW_SEL_LO] <= lvl_q[0];
      o_status_word[SLSMON_SW_SEL_HI] <= lvl_q[1];
      o_safe_out <= safe_out_en_q && hold_q;
    end
  end

  // ****************************************************************
  // Interrupts: request seen, monitoring active, fault
  // ****************************************************************
  logic [2:0] ev;
  logic mon_q;
  logic any_q;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      mon_q <= 1'b0;
      any_q <= 1'b0;
    end else begin
      mon_q <= hold_q;
      any_q <= any_req;
    end
  end
  assign ev = {fault_q & ~o_torque_removal & ~o_stop_one & ~o_stop_two &
               ~o_op_stop_hold, hold_q & ~mon_q,
               any_req & ~any_q};

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      irq_st_q <= 3'h0;
    end else begin
      irq_st_q <= (irq_st_q &
        ~((i_wr && i_addr == SLSMON_A_IRQ_CLR) ? i_wdata[2:0] : 3'h0))
        | ev;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_st_q & irq_en_q);
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      o_rdata <= 32'h0;
      case (i_addr)
        SLSMON_A_CTRL: o_rdata <= {31'h0, safe_out_en_q};
        SLSMON_A_RAMP: o_rdata <= {8'h0, ramp_q};
        SLSMON_A_REACT: o_rdata <= {24'h0, react_q};
        SLSMON_A_STAT: o_rdata <= {22'h0, fault_q, fault_react_q,
                                   enf_lvl_q, lvl_q, state_q};
        SLSMON_A_IRQ_ST: o_rdata <= {29'h0, irq_st_q};
        SLSMON_A_IRQ_EN: o_rdata <= {29'h0, irq_en_q};
        default: begin
          for (int k = 0; k < SLSMON_LEVELS; k++) begin
            if (i_addr == SLSMON_A_LIM0 + 8'(4 * k)) begin
              o_rdata <= {16'h0, lim_q[k]};
            end
          end
        end
      endcase
    end else begin
      o_rdata <= 32'h0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Response well inside ten milliseconds once ramp is short
  chk_req_starts: assert property (@(posedge i_mclk) disable iff (i_srst)
    $rose(any_req) && state_q == SLSMON_IDLE |=> state_q == SLSMON_RAMP)
    else $error("request not taken");
  chk_drop_idle: assert property (@(posedge i_mclk) disable iff (i_srst)
    !any_req && state_q != SLSMON_IDLE |=> state_q == SLSMON_IDLE)
    else $error("no release on idle sources");
  chk_pick_low: assert property (@(posedge i_mclk) disable iff (i_srst)
    any_req |-> req[pick])
    else $error("picked unrequested level");
  chk_fault_sticky: assert property (@(posedge i_mclk) disable iff (i_srst)
    fault_q |=> fault_q)
    else $error("fault dropped");
  chk_overspeed: assert property (@(posedge i_mclk) disable iff (i_srst)
    checking && !fault_q && i_safe_vel > lim_q[enf_lvl_q] |=> fault_q)
    else $error("overspeed missed");
  chk_react_out: assert property (@(posedge i_mclk) disable iff (i_srst)
    $rose(fault_q) |=> (o_torque_removal | o_stop_one | o_stop_two |
                        o_op_stop_hold))
    else $error("no reaction output");
  chk_sel_bits: assert property (@(posedge i_mclk) disable iff (i_srst)
    1'b1 |=> o_status_word[10:9] == $past(lvl_q))
    else $error("level code wrong");
  chk_safe_out: assert property (@(posedge i_mclk) disable iff (i_srst)
    o_safe_out |-> $past(hold_q))
    else $error("safe output without level");
  chk_raise_now: assert property (@(posedge i_mclk) disable iff (i_srst)
    state_q != SLSMON_IDLE && any_req && up_ok && pick != lvl_q
    |=> state_q == SLSMON_MON && enf_lvl_q == $past(pick))
    else $error("raised limit not applied at once");
endmodule // slsmon_top
`default_nettype wire

/* tb/slsmon_ctrl_model.sv */
// Model of the safety controller, safe input wiring and speed feedback
`timescale 1ns/1ps
`default_nettype none
module slsmon_ctrl_model (
  // Clock
  input wire logic i_mclk,
  // Commands from the bench
  input wire logic [3:0] i_bus_cmd,
  input wire logic [3:0] i_pin_cmd,
  input wire logic [15:0] i_vel_cmd,
  // Drive side
  output logic [3:0] o_bus_req = 4'h0,
  output logic [3:0] o_pin_req = 4'h0,
  output logic [15:0] o_safe_vel = 16'h0000
);
  // Telegram and speed feedback follow the drive clock
  always @(posedge i_mclk) begin
    o_bus_req <= i_bus_cmd;
    o_safe_vel <= i_vel_cmd;
  end
  // Contacts switch off-edge, so the synchroniser sees true async input
  always @(negedge i_mclk) begin
    o_pin_req <= i_pin_cmd;
  end
endmodule // slsmon_ctrl_model
`default_nettype wire

/* tb/slsmon_top_test.sv */
// Self-checking testbench for the safe limited speed monitor
`timescale 1ns/1ps
`default_nettype none
module slsmon_top_test
  import slsmon_pkg::*;
;
  localparam int RAMP = 20;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] bus_cmd = 4'h0;
  logic [3:0] pin_cmd = 4'h0;
  logic [3:0] int_req = 4'h0;
  logic [15:0] vel_cmd = 16'h0000;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] bus_req, pin_req;
  logic [15:0] safe_vel, sw;
  logic [31:0] rdata;
  logic safe_out, trq, st1, st2, hold, irq;
  int err_total = 0;
  int checks_done = 0;
  // Limits out of index order, so lowest-limit wins differs from index
  logic [15:0] lim [4] = '{16'h0800, 16'h1000, 16'h0400, 16'h0c00};

  slsmon_ctrl_model u_slsmon_ctrl_model (.i_mclk(mclk), .i_bus_cmd(bus_cmd),
    .i_pin_cmd(pin_cmd), .i_vel_cmd(vel_cmd), .o_bus_req(bus_req),
    .o_pin_req(pin_req), .o_safe_vel(safe_vel));
  slsmon_top u_slsmon_top (.i_mclk(mclk), .i_srst(srst), .i_bus_req(bus_req),
    .i_pin_req(pin_req), .i_int_req(int_req), .i_safe_vel(safe_vel),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_status_word(sw), .o_safe_out(safe_out), .o_torque_removal(trq),
    .o_stop_one(st1), .o_stop_two(st2), .o_op_stop_hold(hold), .o_irq(irq));

  // ****************
  // Helpers
  // ****************
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Land one nanosecond past an edge so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task automatic set_req(input logic [3:0] b, input logic [3:0] p,
                         input logic [3:0] i);
    @(posedge mclk);
    bus_cmd <= b;
    pin_cmd <= p;
    int_req <= i;
  endtask
  task automatic set_vel(input logic [15:0] v);
    @(posedge mclk);
    vel_cmd <= v;
  endtask
  // Bounded wait on the monitoring-active flag
  task automatic wait_on(input logic want, input int cyc);
    int n;
    n = 0;
    while (sw[4] !== want && n < cyc) begin
      tick(1);
      n++;
    end
    chk({31'h0, sw[4]}, {31'h0, want});
  endtask
  task automatic do_reset();
    set_req(4'h0, 4'h0, 4'h0);
    vel_cmd <= 16'h0000;
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
  endtask
  // Limits sit far above normal-motion speed, zero here
  task automatic setup();
    wr_reg(SLSMON_A_CTRL, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr_reg(SLSMON_A_LIM0 + 8'(4 * k), {16'h0, lim[k]});
    end
    wr_reg(SLSMON_A_RAMP, RAMP);
    wr_reg(SLSMON_A_REACT, 32'he4);
    wr_reg(SLSMON_A_IRQ_EN, 32'h2);
  endtask
  // Requests split over fieldbus and pins, then the level code is judged
  task automatic run_level(input logic [3:0] m, input logic [1:0] lvl);
    set_req(m & 4'h5, m & 4'ha, 4'h0);
    wait_on(1'b1, RAMP + 12);
    tick(RAMP + 8);
    chk({30'h0, sw[10:9]}, {30'h0, lvl});
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_defaults();
    chk({31'h0, safe_out}, 32'h0);
    rd_chk(SLSMON_A_LIM0, {16'h0, SLSMON_LIM_RST});
    rd_chk(SLSMON_A_LIM0 + 8'h0c, {16'h0, SLSMON_LIM_RST});
    rd_chk(SLSMON_A_RAMP, {8'h0, SLSMON_RAMP_RST});
    rd_chk(SLSMON_A_REACT, {24'h0, SLSMON_REACT_RST});
    rd_chk(8'h3c, 32'h0);
  endtask
  task automatic t_activate();
    setup();
    set_req(4'h2, 4'h0, 4'h0);
    tick(RAMP / 2);
    chk({31'h0, sw[4]}, 32'h0);
    wait_on(1'b1, RAMP + 12);
    chk({30'h0, sw[10:9]}, 32'h1);
    // Interrupt output trails its status bit by one cycle
    tick(1);
    chk({30'h0, safe_out, irq}, 32'h3);
    rd_chk(SLSMON_A_IRQ_ST, 32'h3);
    wr_reg(SLSMON_A_IRQ_CLR, 32'h3);
    tick(2);
    chk({31'h0, irq}, 32'h0);
    rd_chk(SLSMON_A_IRQ_ST, 32'h0);
    set_req(4'h0, 4'h0, 4'h0);
    wait_on(1'b0, 8);
    tick(1);
    chk({31'h0, safe_out}, 32'h0);
  endtask
  // Sources hand over one to another; supervision must not drop
  task automatic t_sources();
    wr_reg(SLSMON_A_IRQ_EN, 32'h0);
    set_req(4'h0, 4'h1, 4'h0);
    wait_on(1'b1, RAMP + 12);
    chk({31'h0, irq}, 32'h0);
    wr_reg(SLSMON_A_IRQ_EN, 32'h3);
    tick(2);
    chk({31'h0, irq}, 32'h1);
    set_req(4'h1, 4'h0, 4'h0);
    tick(10);
    chk({31'h0, sw[4]}, 32'h1);
    set_req(4'h0, 4'h0, 4'h1);
    tick(10);
    chk({31'h0, sw[4]}, 32'h1);
    set_req(4'h0, 4'h0, 4'h0);
    wait_on(1'b0, 8);
    wr_reg(SLSMON_A_IRQ_CLR, 32'h7);
  endtask
  task automatic t_priority();
    logic [3:0] ms [7] = '{4'h3, 4'ha, 4'hd, 4'h6, 4'hf, 4'h8, 4'h2};
    logic [1:0] ws [7] = '{2'h0, 2'h3, 2'h2, 2'h2, 2'h2, 2'h3, 2'h1};
    for (int n = 0; n < 7; n++) begin
      run_level(ms[n], ws[n]);
      set_req(4'h0, 4'h0, 4'h0);
      wait_on(1'b0, 8);
    end
  endtask
  // Raise is immediate; a lower limit waits, checking the old one
  task automatic t_ramp();
    run_level(4'h6, 2'h2);
    set_req(4'h2, 4'h0, 4'h0);
    tick(6);
    chk({30'h0, sw[10:9]}, 32'h1);
    set_vel(16'h0900);
    tick(6);
    chk({28'h0, hold, st2, st1, trq}, 32'h0);
    set_req(4'h6, 4'h0, 4'h0);
    tick(RAMP - 4);
    chk({28'h0, hold, st2, st1, trq}, 32'h0);
    tick(12);
    chk({28'h0, hold, st2, st1, trq}, 32'h4);
  endtask
  // Each level trips its own reaction, only when strictly over
  task automatic t_reactions();
    for (int k = 0; k < 4; k++) begin
      do_reset();
      setup();
      set_vel(16'hffff);
      tick(8);
      chk({28'h0, hold, st2, st1, trq}, 32'h0);
      set_vel(lim[k]);
      run_level(4'h1 << k, 2'(k));
      chk({28'h0, hold, st2, st1, trq}, 32'h0);
      set_vel(lim[k] + 16'h1);
      tick(8);
      chk({28'h0, hold, st2, st1, trq}, 32'h1 << k);
      rd_chk(SLSMON_A_STAT,
        {22'h0, 1'b1, 2'(k), 2'(k), 2'(k), SLSMON_MON});
    end
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    t_defaults();
    t_activate();
    t_sources();
    t_priority();
    t_ramp();
    t_reactions();
    tally_and_finish();
  end
  // Watchdog, well beyond the thousand or so cycles the run needs
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    tally_and_finish();
  end
endmodule // slsmon_top_test
`default_nettype wire
